// file: verilog/ris_pkg.sv
// Shared constants and types for the reference input stage block.
package ris_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int RIS_NUM_STAGES = 8;
  localparam int RIS_NUM_REFS = 16;
  localparam int RIS_SE_OFFSET = 8;
  localparam int RIS_ADDR_W = 8;
  localparam int RIS_DATA_W = 32;
  localparam int RIS_PIN_W = 18;
  localparam int RIS_FREQ_M_W = 48;
  localparam int RIS_FREQ_N_W = 16;
  localparam int RIS_DIV_W = 16;
  localparam int RIS_FB_W = 10;
  localparam int RIS_ASSOC_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses) and word slots within a stage.
  localparam logic [7:0] RIS_ADDR_SYNTH_CTRL = 8'h00;
  localparam logic [7:0] RIS_ADDR_SYNTH_STATUS = 8'h04;
  localparam logic [7:0] RIS_ADDR_ALARM_ROUTE = 8'h08;
  localparam logic [7:0] RIS_ADDR_REF_ACTIVE = 8'h0C;
  localparam logic [7:0] RIS_ADDR_STAGE_BASE = 8'h80;
  localparam logic [1:0] RIS_WORD_CTRL = 2'h0;
  localparam logic [1:0] RIS_WORD_DIV = 2'h1;
  localparam logic [1:0] RIS_WORD_FREQ_LO = 2'h2;
  localparam logic [1:0] RIS_WORD_FREQ_HI = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer control fields and limits.
  localparam int RIS_SC_DOUBLER_BIT = 0;
  localparam int RIS_SC_FB_LSB = 8;
  localparam logic [31:0] RIS_SC_MASK = 32'h0003FF01;
  localparam logic [31:0] RIS_SC_RESET = 32'h00006C00;
  localparam logic [9:0] RIS_FB_MIN = 10'h06C;
  localparam logic [9:0] RIS_FB_MAX = 10'h22C;

  // Status and alarm route fields.
  localparam int RIS_ST_LOL_STICKY = 0;
  localparam int RIS_ST_UNLOCKED = 1;
  localparam int RIS_ST_BOOT_DONE = 2;
  localparam int RIS_ST_FROM_EEPROM = 3;
  localparam int RIS_ST_FROM_OTP = 4;
  localparam int RIS_AR_ENABLE = 0;
  localparam int RIS_AR_STICKY = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Stage control fields.
  localparam int RIS_CT_MODE_LSB = 0;
  localparam int RIS_CT_PMOS = 2;
  localparam int RIS_CT_EN_P = 3;
  localparam int RIS_CT_EN_S = 4;
  localparam int RIS_CT_INV_P = 5;
  localparam int RIS_CT_INV_S = 6;
  localparam int RIS_CT_BYP_P = 7;
  localparam int RIS_CT_BYP_S = 8;
  localparam int RIS_CT_SYNC_P = 9;
  localparam int RIS_CT_SYNC_S = 10;
  localparam int RIS_CT_ASSOC_P = 11;
  localparam int RIS_CT_ASSOC_S = 15;
  localparam int RIS_CT_W = 19;
  localparam logic [18:0] RIS_CT_RESET = 19'h00000;
  localparam logic [31:0] RIS_DIV_RESET = 32'h00010001;
  localparam logic [1:0] RIS_MODE_RESERVED = 2'h3;

  // Stages that may pair with a general-purpose pin, and its pin slots.
  localparam logic [7:0] RIS_GPIO_STAGE_MASK = 8'h81;
  localparam int RIS_GPIO_PIN_LO = 16;
  localparam int RIS_GPIO_PIN_HI = 17;
  localparam int RIS_GPIO_HI_STAGE = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    RIS_MODE_DIFF,
    RIS_MODE_DUAL_SE,
    RIS_MODE_DIFF_GPIO
  } ris_mode_e;

  typedef enum logic {
    RIS_BOOT_WAIT,
    RIS_BOOT_RUN
  } ris_boot_e;

endpackage

// file: verilog/ris_freq_mem.sv
// Small word memory holding the nominal frequency fractions of all stages.
`timescale 1ns/1ps
`default_nettype none
module ris_freq_mem #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // The array has no reset so it maps onto plain storage cells.
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rd_data <= '0;
    end
    else if (i_rd_en)
    begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// file: verilog/ris_input_stage.sv
// Reference input stages with pin routing, dividers and synth setup.
`timescale 1ns/1ps
`default_nettype none
module ris_input_stage (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [ris_pkg::RIS_ADDR_W-1:0] i_addr,
  input wire logic [ris_pkg::RIS_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ris_pkg::RIS_DATA_W-1:0] o_rdata,
  input wire logic [ris_pkg::RIS_NUM_STAGES-1:0] i_clk_pos,
  input wire logic [ris_pkg::RIS_NUM_STAGES-1:0] i_clk_neg,
  input wire logic [1:0] i_gpio_ref,
  input wire logic i_synth_locked,
  input wire logic i_boot_ready,
  input wire logic i_otp_enable,
  input wire logic i_otp_valid,
  input wire logic [ris_pkg::RIS_DATA_W-1:0] i_otp_ctrl,
  input wire logic i_eeprom_enable,
  input wire logic i_eeprom_valid,
  input wire logic [ris_pkg::RIS_DATA_W-1:0] i_eeprom_ctrl,
  output logic [ris_pkg::RIS_NUM_REFS-1:0] o_ref_edge,
  output logic [ris_pkg::RIS_NUM_REFS-1:0] o_ref_active,
  output logic [ris_pkg::RIS_NUM_REFS-1:0] o_ref_sync,
  output logic [ris_pkg::RIS_NUM_REFS*ris_pkg::RIS_ASSOC_W-1:0] o_sync_assoc,
  output logic [ris_pkg::RIS_NUM_STAGES-1:0] o_buf_diff,
  output logic [ris_pkg::RIS_NUM_STAGES-1:0] o_buf_pmos,
  output logic o_synth_doubler,
  output logic [ris_pkg::RIS_FB_W-1:0] o_synth_fb_div,
  output logic o_gpio_lol,
  output logic o_boot_done
);
  import ris_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and value checks.

  function automatic logic is_stage(input logic [RIS_ADDR_W-1:0] a);
    return a[7] && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] stage_of(input logic [RIS_ADDR_W-1:0] a);
    return a[6:4];
  endfunction

  function automatic logic [1:0] word_of(input logic [RIS_ADDR_W-1:0] a);
    return a[3:2];
  endfunction

  function automatic logic fb_ok(input logic [RIS_DATA_W-1:0] v);
    logic [RIS_FB_W-1:0] fb;
    fb = v[RIS_SC_FB_LSB +: RIS_FB_W];
    return (fb >= RIS_FB_MIN) && (fb <= RIS_FB_MAX);
  endfunction

  function automatic logic ctrl_ok(input logic [RIS_DATA_W-1:0] v,
                                   input logic [2:0] s);
    logic [1:0] m;
    m = v[RIS_CT_MODE_LSB +: 2];
    return (m != RIS_MODE_RESERVED) &&
           !((ris_mode_e'(m) == RIS_MODE_DIFF_GPIO) &&
             !RIS_GPIO_STAGE_MASK[s]);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. A third stage keeps the previous level for edges.

  logic [RIS_PIN_W-1:0] pin_meta;
  logic [RIS_PIN_W-1:0] pin_sync;
  logic [RIS_PIN_W-1:0] pin_prev;
  logic lock_meta;
  logic lock_sync;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_meta <= {i_gpio_ref, i_clk_neg, i_clk_pos};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Reset assumes the synthesizer is locked so no false alarm is raised.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lock_meta <= 1'b1;
      lock_sync <= 1'b1;
    end
    else
    begin
      lock_meta <= i_synth_locked;
      lock_sync <= lock_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot sequence and synthesizer control.

  ris_boot_e boot_state;
  logic boot_load;
  logic [1:0] boot_src;
  logic [RIS_DATA_W-1:0] synth_ctrl;
  logic otp_use;
  logic eeprom_use;
  logic sc_wr;

  assign boot_load = (boot_state == RIS_BOOT_WAIT) && i_boot_ready;
  assign otp_use = i_otp_enable && i_otp_valid && fb_ok(i_otp_ctrl);
  assign eeprom_use = i_eeprom_enable && i_eeprom_valid &&
                      fb_ok(i_eeprom_ctrl);
  assign sc_wr = (boot_state == RIS_BOOT_RUN) && i_wr &&
                 (i_addr == RIS_ADDR_SYNTH_CTRL) && fb_ok(i_wdata);

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      boot_state <= RIS_BOOT_WAIT;
    end
    else
    begin
      case (boot_state)
        RIS_BOOT_WAIT:
        begin
          if (i_boot_ready)
          begin
            boot_state <= RIS_BOOT_RUN;
          end
        end
        RIS_BOOT_RUN:
        begin
          boot_state <= RIS_BOOT_RUN;
        end
        default:
        begin
          boot_state <= RIS_BOOT_WAIT;
        end
      endcase
    end
  end

  // Internal storage wins over the external one when both are usable.
  // A source whose divider is out of range counts as invalid.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      synth_ctrl <= RIS_SC_RESET;
      boot_src <= 2'h0;
    end
    else if (boot_load)
    begin
      if (otp_use)
      begin
        synth_ctrl <= i_otp_ctrl & RIS_SC_MASK;
        boot_src <= 2'h1;
      end
      else if (eeprom_use)
      begin
        synth_ctrl <= i_eeprom_ctrl & RIS_SC_MASK;
        boot_src <= 2'h2;
      end
    end
    else if (sc_wr)
    begin
      synth_ctrl <= i_wdata & RIS_SC_MASK;
    end
  end

  assign o_synth_doubler = synth_ctrl[RIS_SC_DOUBLER_BIT];
  assign o_synth_fb_div = synth_ctrl[RIS_SC_FB_LSB +: RIS_FB_W];
  assign o_boot_done = (boot_state == RIS_BOOT_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // Loss-of-lock alarm. A new loss in the clearing cycle keeps the bit set.

  logic lol_sticky;
  logic [1:0] alarm_route;
  logic lol_set;
  logic lol_clr;

  assign lol_set = o_boot_done && !lock_sync;
  assign lol_clr = i_wr && (i_addr == RIS_ADDR_SYNTH_STATUS) &&
                   i_wdata[RIS_ST_LOL_STICKY];

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lol_sticky <= 1'b0;
    end
    else
    begin
      lol_sticky <= lol_set || (lol_sticky && !lol_clr);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      alarm_route <= 2'h0;
    end
    else if (i_wr && (i_addr == RIS_ADDR_ALARM_ROUTE))
    begin
      alarm_route <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_gpio_lol <= 1'b0;
    end
    else
    begin
      o_gpio_lol <= alarm_route[RIS_AR_ENABLE] &&
                    (alarm_route[RIS_AR_STICKY] ? lol_sticky : lol_set);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stage control and divider registers.

  logic [RIS_CT_W-1:0] stage_ctrl [RIS_NUM_STAGES];
  logic [RIS_DATA_W-1:0] stage_div [RIS_NUM_STAGES];
  logic stage_hit;

  assign stage_hit = i_wr && is_stage(i_addr);

  // A zero divider field would mean divide by one, so the write is dropped.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int s = 0; s < RIS_NUM_STAGES; s++)
      begin
        stage_ctrl[s] <= RIS_CT_RESET;
        stage_div[s] <= RIS_DIV_RESET;
      end
    end
    else if (stage_hit)
    begin
      if ((word_of(i_addr) == RIS_WORD_CTRL) &&
          ctrl_ok(i_wdata, stage_of(i_addr)))
      begin
        stage_ctrl[stage_of(i_addr)] <= i_wdata[RIS_CT_W-1:0];
      end
      if ((word_of(i_addr) == RIS_WORD_DIV) && (i_wdata[15:0] != 16'h0000) &&
          (i_wdata[31:16] != 16'h0000))
      begin
        stage_div[stage_of(i_addr)] <= i_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-reference routing, edge select and divider.

  for (genvar r = 0; r < RIS_NUM_REFS; r++)
  begin : g_ref
    localparam int S = r % RIS_NUM_STAGES;
    localparam bit PRI = (r < RIS_SE_OFFSET);
    localparam int GP = (S == RIS_GPIO_HI_STAGE) ? RIS_GPIO_PIN_HI :
                        RIS_GPIO_PIN_LO;
    ris_mode_e mode;
    logic cur;
    logic prev;
    logic active;
    logic inv;
    logic byp;
    logic sel_edge;
    logic [RIS_DIV_W-1:0] div_m1;
    logic [RIS_DIV_W-1:0] cnt;

    assign mode = ris_mode_e'(stage_ctrl[S][RIS_CT_MODE_LSB +: 2]);

    if (PRI)
    begin : g_pri
      assign cur = pin_sync[S];
      assign prev = pin_prev[S];
      assign active = stage_ctrl[S][RIS_CT_EN_P];
      assign inv = stage_ctrl[S][RIS_CT_INV_P];
      assign byp = stage_ctrl[S][RIS_CT_BYP_P];
      assign div_m1 = stage_div[S][15:0];
    end
    else
    begin : g_sec
      // Negative pin lands on index plus eight; a pin lands on 8 or 15.
      assign cur = (mode == RIS_MODE_DUAL_SE) ? pin_sync[S + RIS_SE_OFFSET] :
                   pin_sync[GP];
      assign prev = (mode == RIS_MODE_DUAL_SE) ? pin_prev[S + RIS_SE_OFFSET] :
                    pin_prev[GP];
      assign active = stage_ctrl[S][RIS_CT_EN_S] &&
                      (mode != RIS_MODE_DIFF);
      assign inv = stage_ctrl[S][RIS_CT_INV_S];
      assign byp = stage_ctrl[S][RIS_CT_BYP_S] ||
                   (mode == RIS_MODE_DIFF_GPIO);
      assign div_m1 = stage_div[S][31:16];
    end

    // Each path picks its own edge, ahead of its divider.
    assign sel_edge = active &&
                      (inv ? (prev && !cur) : (!prev && cur));

    // The compare uses >= so a smaller divider written mid-count ends the
    // current period at once instead of running through a counter wrap.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
      if (!i_rst_b)
      begin
        cnt <= '0;
        o_ref_edge[r] <= 1'b0;
      end
      else if (!active || byp)
      begin
        cnt <= '0;
        o_ref_edge[r] <= sel_edge;
      end
      else if (sel_edge)
      begin
        cnt <= (cnt >= div_m1) ? '0 : cnt + 16'h0001;
        o_ref_edge[r] <= (cnt >= div_m1);
      end
      else
      begin
        o_ref_edge[r] <= 1'b0;
      end
    end

    assign o_ref_active[r] = active;
    assign o_ref_sync[r] = active && (PRI ? stage_ctrl[S][RIS_CT_SYNC_P] :
                           stage_ctrl[S][RIS_CT_SYNC_S]);
    assign o_sync_assoc[r*RIS_ASSOC_W +: RIS_ASSOC_W] = PRI ?
      stage_ctrl[S][RIS_CT_ASSOC_P +: RIS_ASSOC_W] :
      stage_ctrl[S][RIS_CT_ASSOC_S +: RIS_ASSOC_W];
  end

  for (genvar s = 0; s < RIS_NUM_STAGES; s++)
  begin : g_buf
    assign o_buf_diff[s] = stage_ctrl[s][RIS_CT_MODE_LSB +: 2] !=
                           2'(RIS_MODE_DUAL_SE);
    assign o_buf_pmos[s] = o_buf_diff[s] && stage_ctrl[s][RIS_CT_PMOS];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frequency store and read port.

  logic mem_wr;
  logic mem_rd;
  logic [3:0] mem_addr;
  logic [RIS_DATA_W-1:0] mem_rdata;
  logic mem_sel;
  logic [RIS_DATA_W-1:0] reg_rdata;
  logic [RIS_DATA_W-1:0] next_rdata;
  logic [1:0] word_sel;

  assign word_sel = word_of(i_addr);
  assign mem_addr = {stage_of(i_addr), word_sel[0]};
  assign mem_wr = stage_hit && word_sel[1];
  assign mem_rd = i_rd && is_stage(i_addr) && word_sel[1];

  ris_freq_mem #(
    .ADDR_W(4),
    .DATA_W(RIS_DATA_W)
  ) u_freq_mem (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_wr_en(mem_wr),
    .i_wr_addr(mem_addr),
    .i_wr_data(i_wdata),
    .i_rd_en(mem_rd),
    .i_rd_addr(mem_addr),
    .o_rd_data(mem_rdata)
  );

  always_comb
  begin
    next_rdata = '0;
    if (is_stage(i_addr))
    begin
      if (word_of(i_addr) == RIS_WORD_CTRL)
      begin
        next_rdata = {13'h0, stage_ctrl[stage_of(i_addr)]};
      end
      else if (word_of(i_addr) == RIS_WORD_DIV)
      begin
        next_rdata = stage_div[stage_of(i_addr)];
      end
    end
    else if (i_addr == RIS_ADDR_SYNTH_CTRL)
    begin
      next_rdata = synth_ctrl;
    end
    else if (i_addr == RIS_ADDR_SYNTH_STATUS)
    begin
      next_rdata = {27'h0, boot_src[0], boot_src[1], o_boot_done,
                    !lock_sync, lol_sticky};
    end
    else if (i_addr == RIS_ADDR_ALARM_ROUTE)
    begin
      next_rdata = {30'h0, alarm_route};
    end
    else if (i_addr == RIS_ADDR_REF_ACTIVE)
    begin
      next_rdata = {16'h0000, o_ref_active};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      reg_rdata <= '0;
      mem_sel <= 1'b0;
    end
    else
    begin
      reg_rdata <= i_rd ? next_rdata : '0;
      mem_sel <= mem_rd;
    end
  end

  assign o_rdata = mem_sel ? mem_rdata : reg_rdata;

endmodule
`default_nettype wire

// file: testbench/ris_input_stage_props.sv
// Concurrent checks on the ports of the reference input stage block.
`timescale 1ns/1ps
`default_nettype none
module ris_input_stage_props (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [ris_pkg::RIS_ADDR_W-1:0] i_addr,
  input wire logic [ris_pkg::RIS_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic [ris_pkg::RIS_NUM_REFS-1:0] o_ref_edge,
  input wire logic [ris_pkg::RIS_NUM_REFS-1:0] o_ref_active,
  input wire logic [ris_pkg::RIS_NUM_REFS-1:0] o_ref_sync,
  input wire logic [ris_pkg::RIS_NUM_STAGES-1:0] o_buf_diff,
  input wire logic [ris_pkg::RIS_NUM_STAGES-1:0] o_buf_pmos,
  input wire logic o_synth_doubler,
  input wire logic [ris_pkg::RIS_FB_W-1:0] o_synth_fb_div,
  input wire logic o_gpio_lol,
  input wire logic o_boot_done
);
  import ris_pkg::*;
  logic sc_wr;
  logic fb_ok;
  logic [9:0] in_fb;
  logic [10:0] wr_sc;
  assign sc_wr = i_wr && i_addr == RIS_ADDR_SYNTH_CTRL;
  assign in_fb = i_wdata[RIS_SC_FB_LSB+:RIS_FB_W];
  assign fb_ok = in_fb >= RIS_FB_MIN && in_fb <= RIS_FB_MAX;
  always_ff @(posedge i_clock) wr_sc <= {in_fb, i_wdata[RIS_SC_DOUBLER_BIT]};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////
  property p_fb_range; o_synth_fb_div inside {[RIS_FB_MIN:RIS_FB_MAX]}; endproperty
  a_fb_range: assert property (p_fb_range) else $error("fb out of range");
  property p_fb_wr; sc_wr && o_boot_done && fb_ok |=>
    {o_synth_fb_div, o_synth_doubler} == wr_sc; endproperty
  a_fb_wr: assert property (p_fb_wr) else $error("synth write lost");
  property p_fb_ref; sc_wr && !fb_ok |=>
    $stable({o_synth_fb_div, o_synth_doubler}); endproperty
  a_fb_ref: assert property (p_fb_ref) else $error("bad fb taken");
  property p_hold; o_boot_done && !sc_wr |=>
    $stable({o_synth_fb_div, o_synth_doubler}); endproperty
  a_hold: assert property (p_hold) else $error("synth moved");
  property p_boot; o_boot_done |=> o_boot_done; endproperty
  a_boot: assert property (p_boot) else $error("boot done fell");
  property p_lol; !o_boot_done |-> !o_gpio_lol; endproperty
  a_lol: assert property (p_lol) else $error("alarm before boot");
  property p_idle;
    (o_ref_edge & ~o_ref_active & ~$past(o_ref_active)) == '0; endproperty
  a_idle: assert property (p_idle) else $error("edge on idle ref");
  property p_pmos; (o_buf_pmos & ~o_buf_diff) == '0; endproperty
  a_pmos: assert property (p_pmos) else $error("pmos on se");
  property p_sync; (o_ref_sync & ~o_ref_active) == '0; endproperty
  a_sync: assert property (p_sync) else $error("sync on idle");
  property p_pulse; |o_ref_edge |=> (o_ref_edge & $past(o_ref_edge)) == '0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("edge too long");
  c_boot: cover property ($rose(o_boot_done));
  c_edge: cover property (|o_ref_edge);
  c_lol: cover property ($rose(o_gpio_lol));
endmodule
bind ris_input_stage ris_input_stage_props u_props (.i_clock, .i_rst_b,
  .i_addr, .i_wdata, .i_wr, .o_ref_edge, .o_ref_active, .o_ref_sync,
  .o_buf_diff, .o_buf_pmos, .o_synth_doubler, .o_synth_fb_div, .o_gpio_lol,
  .o_boot_done);
`default_nettype wire

// file: testbench/ris_ref_src.sv
// Reference clock source standing at the pins of one input stage.
`timescale 1ns/1ps
`default_nettype none
module ris_ref_src #(
  parameter int HALF_NS = 17
) (
  output logic o_pos,
  output logic o_neg
);
  initial
  begin
    o_pos = 1'b0;
    o_neg = 1'b1;
  end
  // The source stops between bursts so edge counts stay exact.
  task automatic send(input int n);
    repeat (2 * n)
    begin
      #(HALF_NS);
      o_pos = ~o_pos;
      o_neg = ~o_neg;
    end
    #(HALF_NS);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the reference input stage block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ris_pkg::*;
  logic i_clock, i_rst_b, i_wr, i_rd, i_synth_locked, i_boot_ready;
  logic i_otp_enable, i_otp_valid, i_eeprom_enable, i_eeprom_valid;
  logic [7:0] i_addr, o_buf_diff, o_buf_pmos;
  logic [31:0] i_wdata, i_otp_ctrl, i_eeprom_ctrl, o_rdata, sc, v;
  logic [1:0] i_gpio_ref;
  logic [15:0] o_ref_edge, o_ref_active, o_ref_sync;
  logic [63:0] o_sync_assoc;
  logic [9:0] o_synth_fb_div;
  logic [9:0] fbv[5];
  logic o_synth_doubler, o_gpio_lol, o_boot_done, src_pos, src_neg, rd_seen;
  wire [7:0] i_clk_pos;
  wire [7:0] i_clk_neg;
  logic [31:0] exp_q[$];
  int bad_count, checks_done, seed, edge_cnt[16];
  assign i_clk_pos = {6'h0, src_pos, 1'b0};
  assign i_clk_neg = {6'h0, src_neg, 1'b0};
  ris_ref_src src (.o_pos(src_pos), .o_neg(src_neg));
  ris_input_stage dut (.i_clock, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_clk_pos, .i_clk_neg, .i_gpio_ref, .i_synth_locked,
    .i_boot_ready, .i_otp_enable, .i_otp_valid, .i_otp_ctrl,
    .i_eeprom_enable, .i_eeprom_valid, .i_eeprom_ctrl, .o_ref_edge,
    .o_ref_active, .o_ref_sync, .o_sync_assoc, .o_buf_diff, .o_buf_pmos,
    .o_synth_doubler, .o_synth_fb_div, .o_gpio_lol, .o_boot_done);
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      bad_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe.
  always @(posedge i_clock) rd_seen <= i_rd;
  always @(negedge i_clock)
  begin
    for (int k = 0; k < 16; k++) edge_cnt[k] += o_ref_edge[k];
    if (rd_seen === 1'b1)
      chk(o_rdata, exp_q.pop_front());
  end
  initial
  begin
    #100000;
    $display("Error at %0t: watchdog expired", $time);
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////
  initial
  begin
    seed = 53;
    {i_wr, i_rd, i_synth_locked, i_boot_ready} = 4'h2;
    {i_otp_enable, i_otp_valid, i_eeprom_enable, i_eeprom_valid} = 4'hF;
    i_addr = 8'h00;
    i_wdata = 32'h00000000;
    i_otp_ctrl = 32'h0000C801;
    i_eeprom_ctrl = 32'h00012C00;
    i_gpio_ref = 2'h0;
    i_rst_b = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    settle(1);
    chk(o_synth_fb_div, 32'h6C);
    chk({o_buf_diff, o_boot_done}, 32'h1FE);
    rd(8'h84, RIS_DIV_RESET);
    wr(RIS_ADDR_SYNTH_CTRL, 32'h00012C00);
    settle(1);
    chk(o_synth_fb_div, 32'h6C);
    @(posedge i_clock);
    i_boot_ready <= 1'b1;
    for (int k = 0; k < 20 && o_boot_done !== 1'b1; k++) @(posedge i_clock);
    settle(1);
    chk({o_boot_done, o_synth_doubler, o_synth_fb_div}, 32'hCC8);
    rd(RIS_ADDR_SYNTH_STATUS, 32'h14);
    fbv = '{10'h06B, 10'h06C, 10'h22C, 10'h22D, 10'h06C};
    fbv[4] = fbv[4] + {2'h0, 8'($random(seed))};
    sc = 32'h0000C801;
    foreach (fbv[k])
    begin
      v = {14'h0, fbv[k], 7'h0, k[0]};
      wr(RIS_ADDR_SYNTH_CTRL, v);
      if (fbv[k] >= RIS_FB_MIN && fbv[k] <= RIS_FB_MAX)
        sc = v;
      rd(RIS_ADDR_SYNTH_CTRL, sc);
    end
    wr(RIS_ADDR_ALARM_ROUTE, 32'h1);
    i_synth_locked <= 1'b0;
    settle(6);
    chk(o_gpio_lol, 32'h1);
    rd(RIS_ADDR_SYNTH_STATUS, 32'h17);
    i_synth_locked <= 1'b1;
    settle(6);
    chk(o_gpio_lol, 32'h0);
    wr(RIS_ADDR_SYNTH_STATUS, 32'h1);
    rd(RIS_ADDR_SYNTH_STATUS, 32'h14);
    rd(8'h40, 32'h0);
    v = $random(seed);
    wr(8'h98, v);
    rd(8'h98, v);
    v = $random(seed);
    wr(8'h9C, v);
    rd(8'h9C, v);
    sc = 32'(1 | 1 << RIS_CT_PMOS | 1 << RIS_CT_EN_P | 1 << RIS_CT_EN_S |
      1 << RIS_CT_INV_S | 1 << RIS_CT_BYP_S | 1 << RIS_CT_SYNC_P |
      3 << RIS_CT_ASSOC_P);
    wr(8'h94, 32'h00010002);
    wr(8'h90, sc);
    settle(1);
    chk(o_ref_active, 32'h0202);
    chk({o_buf_diff[1], o_buf_pmos[1]}, 32'h0);
    chk({o_ref_sync, o_sync_assoc[7:4]}, 32'h00023);
    wr(8'h90, 32'h2);
    wr(8'h90, 32'h3);
    wr(8'h94, 32'h00000005);
    rd(8'h90, sc);
    rd(8'h94, 32'h00010002);
    settle(4);
    src.send(6);
    settle(6);
    chk(edge_cnt[1], 32'h2);
    chk(edge_cnt[9], 32'h6);
    wr(8'h90, 32'h1);
    src.send(3);
    settle(6);
    chk({edge_cnt[1][7:0], edge_cnt[9][7:0]}, 32'h0206);
    wr(8'h80, 32'h1A);
    wr(8'hA0, 32'h0C);
    settle(1);
    chk(o_ref_active, 32'h0105);
    chk({o_buf_diff[2:0], o_buf_pmos}, 32'h0504);
    // Pin 0 feeds index 8 undivided, although its divider field is 1.
    repeat (8)
    begin
      repeat (3) @(posedge i_clock);
      i_gpio_ref <= ~i_gpio_ref & 2'h1;
    end
    settle(6);
    chk(edge_cnt[8], 32'h4);
    rd(RIS_ADDR_REF_ACTIVE, 32'h0105);
    i_boot_ready <= 1'b0;
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    settle(1);
    chk({o_ref_active, o_synth_fb_div}, 32'h006C);
    print_verdict();
  end
endmodule
`default_nettype wire
